/* File: rtl/oct_pkg.sv */
// package for the overcurrent stage timing block: register map, reset values,
// timing constants, stage states and shared arithmetic.
// assumes a single 250 MHz clock and 16-bit current magnitudes from the front end.
package oct_pkg;

  // =====================================================================
  // sizes
  localparam int N_STAGE = 6;
  localparam int CUR_W = 16;
  localparam int CNT_W = 20;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int STAT_W = 14;
  localparam int TRIP_BIT_POS = 8;
  localparam int DIV_W = 18;

  // =====================================================================
  // register byte offsets
  localparam logic [ADDR_W-1:0] ADDR_THR_BASE = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_DLY_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_P1 = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_E1 = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_E2 = 8'h48;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h54;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h58;
  localparam logic [ADDR_W-1:0] ADDR_LIVE = 8'h5C;

  // =====================================================================
  // reset values
  localparam logic [CUR_W-1:0] THR_RESET = 16'hFFFF;
  localparam logic [CNT_W-1:0] DLY_RESET = 20'h00000;
  localparam logic [CNT_W-1:0] HOLD_RESET = 20'h00000;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [STAT_W-1:0] MASK_RESET = 14'h0000;

  // =====================================================================
  // timing: one tick per millisecond of a 250 MHz clock
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;

  // dropout level is 95 percent of threshold
  localparam logic [4:0] DROP_NUM = 5'h13;
  localparam logic [4:0] DROP_DEN = 5'h14;

  // =====================================================================
  // stage timer states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_TIME = 3'b010,
    ST_DROP = 3'b100
  } oct_state_e;

  // =====================================================================
  // shared arithmetic
  function automatic logic [CUR_W-1:0] oct_max3(input logic [CUR_W-1:0] a, input logic [CUR_W-1:0] b,
                                                input logic [CUR_W-1:0] c);
    logic [CUR_W-1:0] m;
    m = (a > b) ? a : b;
    return (c > m) ? c : m;
  endfunction

  function automatic logic oct_below_drop(input logic [CUR_W-1:0] cur, input logic [CUR_W-1:0] thr);
    logic [CUR_W+4:0] lhs;
    logic [CUR_W+4:0] rhs;
    lhs = {5'h00, cur} * {16'h0000, DROP_DEN};
    rhs = {5'h00, thr} * {16'h0000, DROP_NUM};
    return lhs < rhs;
  endfunction

  // inverse mode advances faster at higher multiples of threshold
  function automatic logic [CNT_W-1:0] oct_step(input logic [CUR_W-1:0] cur, input logic [CUR_W-1:0] thr,
                                                input logic inverse);
    logic [CUR_W+1:0] c;
    logic [CUR_W+1:0] t;
    c = {2'h0, cur};
    t = {2'h0, thr};
    if (!inverse || c < (t << 1)) begin
      return 20'h00001;
    end else if (c < (t << 2)) begin
      return 20'h00002;
    end else begin
      return 20'h00004;
    end
  endfunction

  function automatic logic [CNT_W-1:0] oct_sat_add(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
    logic [CNT_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[CNT_W] ? {CNT_W{1'b1}} : s[CNT_W-1:0];
  endfunction

endpackage

/* File: rtl/oct_stage.sv */
// one overcurrent stage: pickup, delay timer, blocking freeze, dropout hold, start and trip.
// assumes tick is a one-cycle enable and all inputs are synchronous to ref_clk.
`timescale 1ns/100ps
module oct_stage (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tick,
  // measurement and settings
  input wire logic [oct_pkg::CUR_W-1:0] current,
  input wire logic [oct_pkg::CUR_W-1:0] threshold,
  input wire logic [oct_pkg::CNT_W-1:0] delay,
  input wire logic [oct_pkg::CNT_W-1:0] hold_time,
  input wire logic hold_en,
  input wire logic inverse,
  input wire logic block,
  // stage outputs
  output logic start,
  output logic trip
);
  import oct_pkg::*;

  typedef struct packed {
    oct_state_e st;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] hold;
    logic tripped;
    logic start;
    logic trip;
  } oct_stage_s;

  oct_stage_s s;
  oct_stage_s next_s;
  logic pickup;
  logic below;

  // =====================================================================
  // timer
  always_comb begin
    pickup = current > threshold;
    below = oct_below_drop(current, threshold);
    next_s = s;
    case (s.st)
      ST_IDLE: begin
        if (pickup) begin
          next_s.st = ST_TIME;
        end
      end
      ST_TIME: begin
        if (pickup) begin
          if (tick && !block) begin
            next_s.count = oct_sat_add(s.count, oct_step(current, threshold, inverse));
          end
        end else if (below) begin
          if (s.tripped || !hold_en || hold_time == HOLD_RESET) begin
            next_s.st = ST_IDLE;
            next_s.count = '0;
          end else begin
            next_s.st = ST_DROP;
            next_s.hold = '0;
          end
        end
      end
      ST_DROP: begin
        if (pickup) begin
          next_s.st = ST_TIME;
          next_s.hold = '0;
        end else if (!below) begin
          next_s.hold = '0;
        end else if (tick) begin
          if (s.hold + 20'h00001 >= hold_time) begin
            next_s.st = ST_IDLE;
            next_s.count = '0;
            next_s.hold = '0;
          end else begin
            next_s.hold = s.hold + 20'h00001;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
        next_s.count = '0;
        next_s.hold = '0;
      end
    endcase
    next_s.start = pickup;
    next_s.trip = pickup && !block && next_s.count >= delay;
    if (next_s.st == ST_IDLE) begin
      next_s.tripped = 1'b0;
    end else if (next_s.trip) begin
      next_s.tripped = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '{st: ST_IDLE, count: '0, hold: '0, tripped: 1'b0, start: 1'b0, trip: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign start = s.start;
  assign trip = s.trip;

  // =====================================================================
  // checks
  AST_TRIP_CAUSE: assert property (@(posedge ref_clk) disable iff (reset)
    trip |-> $past(pickup) && !$past(block) && (s.count >= $past(delay)))
    else $error("trip without pickup, elapsed delay and free blocking");
  AST_BLOCK_FREEZE: assert property (@(posedge ref_clk) disable iff (reset)
    (s.st == ST_TIME && block && pickup) |=> s.count == $past(s.count))
    else $error("timer advanced while blocked");
  AST_RESUME_HELD: assert property (@(posedge ref_clk) disable iff (reset)
    (s.st == ST_TIME && $fell(block) && pickup) |=> s.count >= $past(s.count))
    else $error("timer restarted after blocking release");
  AST_START_PICKUP: assert property (@(posedge ref_clk) disable iff (reset)
    pickup |=> start)
    else $error("start missing one cycle after pickup");
  AST_TRIPPED_DROP: assert property (@(posedge ref_clk) disable iff (reset)
    (s.st == ST_TIME && s.tripped && below) |=> s.st == ST_IDLE && s.count == '0)
    else $error("tripped stage not cleared at once on dropout");
  AST_HOLD_BAND: assert property (@(posedge ref_clk) disable iff (reset)
    (s.st != ST_IDLE && !pickup && !below) |=> s.count == $past(s.count) && s.st != ST_IDLE)
    else $error("delay cleared above dropout level");
  AST_FIXED_STEP: assert property (@(posedge ref_clk) disable iff (reset)
    (!inverse && s.st == ST_TIME && pickup && tick && !block && s.count < 20'h0FFFF)
    |=> s.count == $past(s.count) + 20'h00001)
    else $error("fixed delay did not advance one per tick");
  COV_TRIP: cover property (@(posedge ref_clk) disable iff (reset) $rose(trip));
  COV_BLOCK_RESUME: cover property (@(posedge ref_clk) disable iff (reset)
    (s.st == ST_TIME && block) ##1 (s.st == ST_TIME && !block && pickup));
  COV_HOLD_DONE: cover property (@(posedge ref_clk) disable iff (reset)
    (s.st == ST_DROP) ##1 (s.st == ST_IDLE));

endmodule

/* File: rtl/oct_top.sv */
// overcurrent stage timing: three phase and three earth stages behind a register port.
// assumes current magnitudes and blocking inputs are synchronous to ref_clk.
//
// Overview of operation
// - three phase and three earth stages, each with own threshold and delay
// - stages one and two select fixed or inverse delay
// - stage three is always fixed delay
// - earth settings stored apart from phase settings
// - trip needs current above threshold, elapsed delay, and no blocking
// - phase pickup is OR of phase A, B and C comparisons
// - earth stages use the same stage logic on earth current
// - blocking freezes a stage timer and keeps its count
// - after blocking release timing resumes from the held count
// - start asserts as soon as the stage timer begins running
// - overcurrent recognised well within 20 ms before timing
// - dropout hold on phase stage one and earth stages one and two
// - delay cleared only after current below 95 percent for hold time; stages without dropout hold clear it at once below 95 percent
// - a tripped stage clears its delay immediately on dropout
//
// Implementation choices: the address map and strobed register access.
`timescale 1ns/100ps
module oct_top #(
  parameter int TICK_CYCLES = oct_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // measured current magnitudes
  input wire logic [oct_pkg::CUR_W-1:0] phase_a_current,
  input wire logic [oct_pkg::CUR_W-1:0] phase_b_current,
  input wire logic [oct_pkg::CUR_W-1:0] phase_c_current,
  input wire logic [oct_pkg::CUR_W-1:0] earth_current,
  // blocking inputs, stages 0..2 phase, 3..5 earth
  input wire logic [oct_pkg::N_STAGE-1:0] stage_block,
  // register port
  input wire logic [oct_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [oct_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [oct_pkg::DATA_W-1:0] reg_rdata,
  // interrupt
  output logic irq,
  // stage outputs
  output logic [oct_pkg::N_STAGE-1:0] stage_start,
  output logic [oct_pkg::N_STAGE-1:0] stage_trip
);
  import oct_pkg::*;

  typedef struct packed {
    logic [N_STAGE-1:0][CUR_W-1:0] thr;
    logic [N_STAGE-1:0][CNT_W-1:0] dly;
    logic [2:0][CNT_W-1:0] hold;
    logic [3:0] mode;
    logic [STAT_W-1:0] status;
    logic [STAT_W-1:0] mask;
    logic [DIV_W-1:0] div;
    logic tick;
    logic [N_STAGE-1:0] start_q;
    logic [N_STAGE-1:0] trip_q;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } oct_top_s;

  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);

  oct_top_s s;
  oct_top_s next_s;
  logic [N_STAGE-1:0] start_w;
  logic [N_STAGE-1:0] trip_w;
  logic [N_STAGE-1:0][CUR_W-1:0] stage_cur;
  logic [N_STAGE-1:0] inverse_sel;
  logic [N_STAGE-1:0] hold_sel;
  logic [N_STAGE-1:0][CNT_W-1:0] hold_val;
  logic [STAT_W-1:0] events;

  // =====================================================================
  // stage wiring
  always_comb begin
    stage_cur[0] = oct_max3(phase_a_current, phase_b_current, phase_c_current);
    stage_cur[1] = stage_cur[0];
    stage_cur[2] = stage_cur[0];
    stage_cur[3] = earth_current;
    stage_cur[4] = earth_current;
    stage_cur[5] = earth_current;
    inverse_sel = {1'b0, s.mode[3], s.mode[2], 1'b0, s.mode[1], s.mode[0]};
    hold_sel = 6'b011001;
    hold_val[0] = s.hold[0];
    hold_val[1] = HOLD_RESET;
    hold_val[2] = HOLD_RESET;
    hold_val[3] = s.hold[1];
    hold_val[4] = s.hold[2];
    hold_val[5] = HOLD_RESET;
  end

  for (genvar g = 0; g < N_STAGE; g++) begin : g_stage
    oct_stage u_stage (
      .ref_clk(ref_clk),
      .reset(reset),
      .tick(s.tick),
      .current(stage_cur[g]),
      .threshold(s.thr[g]),
      .delay(s.dly[g]),
      .hold_time(hold_val[g]),
      .hold_en(hold_sel[g]),
      .inverse(inverse_sel[g]),
      .block(stage_block[g]),
      .start(start_w[g]),
      .trip(trip_w[g])
    );
  end

  // =====================================================================
  // tick divider, registers, status and interrupt
  always_comb begin
    next_s = s;
    next_s.start_q = start_w;
    next_s.trip_q = trip_w;
    if (s.div == DIV_LAST) begin
      next_s.div = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.div = s.div + 18'h00001;
      next_s.tick = 1'b0;
    end
    events = '0;
    events[N_STAGE-1:0] = start_w & ~s.start_q;
    events[TRIP_BIT_POS +: N_STAGE] = trip_w & ~s.trip_q;
    if (reg_write) begin
      for (int i = 0; i < N_STAGE; i++) begin
        if (reg_addr == ADDR_THR_BASE + ADDR_W'(4 * i)) begin
          next_s.thr[i] = reg_wdata[CUR_W-1:0];
        end
        if (reg_addr == ADDR_DLY_BASE + ADDR_W'(4 * i)) begin
          next_s.dly[i] = reg_wdata[CNT_W-1:0];
        end
      end
      case (reg_addr)
        ADDR_HOLD_P1: begin
          next_s.hold[0] = reg_wdata[CNT_W-1:0];
        end
        ADDR_HOLD_E1: begin
          next_s.hold[1] = reg_wdata[CNT_W-1:0];
        end
        ADDR_HOLD_E2: begin
          next_s.hold[2] = reg_wdata[CNT_W-1:0];
        end
        ADDR_MODE: begin
          next_s.mode = reg_wdata[3:0];
        end
        ADDR_STATUS: begin
          next_s.status = s.status & ~reg_wdata[STAT_W-1:0];
        end
        ADDR_MASK: begin
          next_s.mask = reg_wdata[STAT_W-1:0];
        end
        default: begin
        end
      endcase
    end
    next_s.status = next_s.status | events;
    next_s.irq = |(next_s.status & next_s.mask);
    next_s.rdata = '0;
    if (reg_read) begin
      for (int i = 0; i < N_STAGE; i++) begin
        if (reg_addr == ADDR_THR_BASE + ADDR_W'(4 * i)) begin
          next_s.rdata = {16'h0000, s.thr[i]};
        end
        if (reg_addr == ADDR_DLY_BASE + ADDR_W'(4 * i)) begin
          next_s.rdata = {12'h000, s.dly[i]};
        end
      end
      case (reg_addr)
        ADDR_HOLD_P1: begin
          next_s.rdata = {12'h000, s.hold[0]};
        end
        ADDR_HOLD_E1: begin
          next_s.rdata = {12'h000, s.hold[1]};
        end
        ADDR_HOLD_E2: begin
          next_s.rdata = {12'h000, s.hold[2]};
        end
        ADDR_MODE: begin
          next_s.rdata = {28'h0000000, s.mode};
        end
        ADDR_STATUS: begin
          next_s.rdata = {18'h00000, s.status};
        end
        ADDR_MASK: begin
          next_s.rdata = {18'h00000, s.mask};
        end
        ADDR_LIVE: begin
          next_s.rdata = {18'h00000, s.trip_q, 2'h0, s.start_q};
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s <= '{thr: {N_STAGE{THR_RESET}}, dly: {N_STAGE{DLY_RESET}}, hold: {3{HOLD_RESET}}, mode: MODE_RESET,
             status: '0, mask: MASK_RESET, div: '0, tick: 1'b0, start_q: '0, trip_q: '0, rdata: '0,
             irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign irq = s.irq;
  assign stage_start = start_w;
  assign stage_trip = trip_w;

  // =====================================================================
  // checks
  AST_THIRD_FIXED: assert property (@(posedge ref_clk) disable iff (reset)
    $changed(s.mode) |-> !inverse_sel[2] && !inverse_sel[5])
    else $error("third stage took an inverse delay");
  AST_TICK_SPACING: assert property (@(posedge ref_clk) disable iff (reset)
    s.tick |=> !s.tick)
    else $error("tick enable longer than one cycle");
  AST_START_EVENT: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(stage_start[0]) |=> s.status[0] ##1 (s.status[0] || $past(reg_write)))
    else $error("start event not recorded in status");
  AST_EARTH_APART: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_write && reg_addr == ADDR_THR_BASE) |=> s.thr[3] == $past(s.thr[3]))
    else $error("phase threshold write changed an earth threshold");
  AST_MASK_READ: assert property (@(posedge ref_clk) disable iff (reset)
    (reg_read && reg_addr == ADDR_MASK) |=> reg_rdata == {18'h00000, $past(s.mask)})
    else $error("mask read data wrong");
  AST_PHASE_OR: assert property (@(posedge ref_clk) disable iff (reset)
    (phase_a_current > s.thr[0] || phase_b_current > s.thr[0] || phase_c_current > s.thr[0])
    |=> stage_start[0])
    else $error("phase stage one missed a single phase above threshold");
  AST_EARTH_PICKUP: assert property (@(posedge ref_clk) disable iff (reset)
    (earth_current > s.thr[3]) |=> stage_start[3])
    else $error("earth stage one missed earth current above threshold");
  COV_IRQ: cover property (@(posedge ref_clk) disable iff (reset) $rose(irq));
  COV_EARTH_TRIP: cover property (@(posedge ref_clk) disable iff (reset) $rose(stage_trip[3]));

endmodule

/* File: verification/oct_front_model.sv */
// model of the measurement front end and the downstream blocking relay.
// assumes the bench sets wanted values; they reach the block one clock later.
`timescale 1ns/100ps
module oct_front_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // wanted values
  input wire logic [oct_pkg::CUR_W-1:0] want_a,
  input wire logic [oct_pkg::CUR_W-1:0] want_b,
  input wire logic [oct_pkg::CUR_W-1:0] want_c,
  input wire logic [oct_pkg::CUR_W-1:0] want_e,
  input wire logic [oct_pkg::N_STAGE-1:0] want_block,
  // towards the block
  output logic [oct_pkg::CUR_W-1:0] phase_a_current,
  output logic [oct_pkg::CUR_W-1:0] phase_b_current,
  output logic [oct_pkg::CUR_W-1:0] phase_c_current,
  output logic [oct_pkg::CUR_W-1:0] earth_current,
  output logic [oct_pkg::N_STAGE-1:0] stage_block
);
  import oct_pkg::*;
  // =====================================================================
  // registered magnitudes and blocking
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_a_current <= '0;
      phase_b_current <= '0;
      phase_c_current <= '0;
      earth_current <= '0;
      stage_block <= '0;
    end else begin
      phase_a_current <= want_a;
      phase_b_current <= want_b;
      phase_c_current <= want_c;
      earth_current <= want_e;
      stage_block <= want_block;
    end
  end
endmodule

/* File: verification/oct_top_tb_top.sv */
// self-checking bench for the overcurrent stage timing block.
// assumes a short tick of 4 clocks and the front end model beside the block.
`timescale 1ns/100ps
module oct_top_tb_top;
  import oct_pkg::*;
  localparam int TK = 4;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [CUR_W-1:0] want_a = '0;
  logic [CUR_W-1:0] want_b = '0;
  logic [CUR_W-1:0] want_c = '0;
  logic [CUR_W-1:0] want_e = '0;
  logic [N_STAGE-1:0] want_block = '0;
  logic [CUR_W-1:0] ia;
  logic [CUR_W-1:0] ib;
  logic [CUR_W-1:0] ic;
  logic [CUR_W-1:0] ie;
  logic [N_STAGE-1:0] blk;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic irq;
  logic [N_STAGE-1:0] stage_start;
  logic [N_STAGE-1:0] stage_trip;
  logic rd_d = 1'b0;
  logic [DATA_W-1:0] rd_q[$];
  logic [CUR_W-1:0] thr;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #2 ref_clk = ~ref_clk;

  oct_front_model u_front (.ref_clk(ref_clk), .reset(reset), .want_a(want_a), .want_b(want_b),
    .want_c(want_c), .want_e(want_e), .want_block(want_block), .phase_a_current(ia),
    .phase_b_current(ib), .phase_c_current(ic), .earth_current(ie), .stage_block(blk));

  oct_top #(.TICK_CYCLES(TK)) u_dut (.ref_clk(ref_clk), .reset(reset), .phase_a_current(ia),
    .phase_b_current(ib), .phase_c_current(ic), .earth_current(ie), .stage_block(blk),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .stage_start(stage_start), .stage_trip(stage_trip));

  // =====================================================================
  // compare and closing
  task automatic cmp(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk(input logic [5:0] st, input logic [5:0] tr, input logic iq);
    #1;
    cmp({19'h0, stage_start, stage_trip, irq}, {19'h0, st, tr, iq});
  endtask

  task automatic stop_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // =====================================================================
  // read data watcher
  always @(posedge ref_clk) begin
    rd_d <= reg_read;
    if (rd_d && rd_q.size() > 0) begin
      cmp(reg_rdata, rd_q.pop_front());
    end
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      stop_test();
    end
  end

  // =====================================================================
  // drivers
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    rd_q.push_back(exp);
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask

  task automatic drv(input int s, input logic [CUR_W-1:0] v, input logic [5:0] b);
    @(posedge ref_clk);
    want_a <= (s == 0) ? v : 16'h0000;
    want_b <= (s == 1) ? v : 16'h0000;
    want_c <= (s == 2) ? v : 16'h0000;
    want_e <= (s >= 3) ? v : 16'h0000;
    want_block <= b;
  endtask

  function automatic logic [ADDR_W-1:0] adr(input logic [ADDR_W-1:0] base, input int s);
    return base + 8'(4 * s);
  endfunction

  task automatic setup(input int s, input logic [CNT_W-1:0] d);
    thr = 16'h0100 + 16'($urandom_range(16'h0E00));
    wr(adr(ADDR_THR_BASE, s), {16'h0, thr});
    wr(adr(ADDR_DLY_BASE, s), {12'h0, d});
  endtask

  task automatic clean(input int s);
    drv(s, 16'h0000, 6'h00);
    wr(adr(ADDR_THR_BASE, s), 32'hFFFF);
    cyc(2);
  endtask

  // =====================================================================
  // tests
  initial begin
    void'($urandom(32'hE380));
    cyc(8);
    reset <= 1'b0;
    rd(adr(ADDR_THR_BASE, 5), 32'hFFFF);
    rd(ADDR_DLY_BASE, 32'h0);
    rd(ADDR_HOLD_E2, 32'h0);
    rd(ADDR_MODE, 32'h0);
    rd(ADDR_MASK, 32'h0);
    wr(8'h60, 32'hFFFFFFFF);
    rd(8'h60, 32'h0);
    wr(adr(ADDR_DLY_BASE, 4), 32'hFFFABCDE);
    rd(adr(ADDR_DLY_BASE, 4), 32'h000ABCDE);
    $display("test registers done");
    wr(ADDR_HOLD_P1, 32'h64);
    wr(ADDR_HOLD_E1, 32'h64);
    wr(ADDR_HOLD_E2, 32'h64);
    for (int s = 0; s < 6; s++) begin
      setup(s, 20'h4);
      drv(s, thr << 1, 6'h00);
      cyc(3);
      chk(6'h01 << s, 6'h00, 1'b0);
      cyc(7);
      chk(6'h01 << s, 6'h00, 1'b0);
      cyc(14);
      chk(6'h01 << s, 6'h01 << s, 1'b0);
      drv(s, 16'h0000, 6'h00);
      cyc(3);
      chk(6'h00, 6'h00, 1'b0);
      drv(s, thr << 1, 6'h00);
      cyc(10);
      chk(6'h01 << s, 6'h00, 1'b0);
      clean(s);
    end
    $display("test stages done");
    setup(1, 20'h8);
    drv(1, thr << 1, 6'h00);
    cyc(18);
    drv(1, thr << 1, 6'h02);
    cyc(40);
    chk(6'h02, 6'h00, 1'b0);
    rd(ADDR_LIVE, 32'h0002);
    drv(1, thr << 1, 6'h00);
    cyc(5);
    chk(6'h02, 6'h00, 1'b0);
    cyc(15);
    chk(6'h02, 6'h02, 1'b0);
    clean(1);
    $display("test blocking done");
    wr(ADDR_HOLD_P1, 32'h4);
    setup(0, 20'h8);
    drv(0, thr << 1, 6'h00);
    cyc(18);
    drv(0, 16'h0000, 6'h00);
    cyc(3);
    chk(6'h00, 6'h00, 1'b0);
    drv(0, thr - 16'h0001, 6'h00);
    cyc(24);
    chk(6'h00, 6'h00, 1'b0);
    drv(0, thr << 1, 6'h00);
    cyc(20);
    chk(6'h01, 6'h01, 1'b0);
    rd(ADDR_LIVE, 32'h0101);
    clean(0);
    $display("test hold done");
    wr(ADDR_MODE, 32'hF);
    wr(ADDR_STATUS, 32'h3F3F);
    wr(ADDR_MASK, 32'h0100);
    rd(ADDR_STATUS, 32'h0);
    for (int k = 0; k < 2; k++) begin
      setup(2 * k, 20'h8);
      drv(2 * k, thr << 2, 6'h00);
      cyc(14);
      chk(6'h01 << (2 * k), (k == 0) ? 6'h01 : 6'h00, k == 0);
      clean(2 * k);
      if (k == 0) begin
        rd(ADDR_STATUS, 32'h0101);
        wr(ADDR_STATUS, 32'h0100);
        cyc(2);
        chk(6'h00, 6'h00, 1'b0);
        rd(ADDR_STATUS, 32'h0001);
      end
    end
    $display("test inverse and interrupt done");
    cyc(4);
    stop_test();
  end
endmodule
